// >>> design/rwu_top.sv
// Reset sequencer, two watchdog flavours and their AHB-Lite registers.
// Assumes the reset pin is resolved outside from rst_pin_oe/rst_pin_out,
// and that resetn is the power-on detector, released once the oscillator runs.
//
// Decided for this implementation: the AHB-Lite slave port.
`timescale 1ns/1ps
module rwu_top #(
    parameter int WD1_BASE_LOG2 = rwu_pkg::WD1_BASE_LOG2_DEF,
    parameter int WD2_BITS = rwu_pkg::WD2_BITS_DEF
) (
    input wire logic clock,
    input wire logic resetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic first_compat_mode,
    input wire logic option_wdog_enable,
    input wire logic clock_fail,
    input wire logic stop_entry,
    input wire logic [7:0] port_interrupt_option,
    input wire logic rst_pin_in,
    output logic rst_pin_out,
    output logic rst_pin_oe,
    output logic cpu_reset,
    output logic reset_vector_load
);
    import rwu_pkg::*;

    localparam int W1 = WD1_BASE_LOG2 + 6;

    // Refuse widths the counters cannot serve
    if (WD1_BASE_LOG2 < 1 || WD1_BASE_LOG2 > 24) begin : g_chk1
        $error("WD1_BASE_LOG2 out of range");
    end
    if (WD2_BITS < 2 || WD2_BITS > 30) begin : g_chk2
        $error("WD2_BITS out of range");
    end

    // Synchroniser stages: mode, option enable, pin, clock fail
    logic [3:0] sync_a;
    logic [3:0] sync_b;
    logic mode1; // First compatibility mode
    logic opt_en; // Option-programmed enable
    logic pin_hi; // Reset pin level, synced
    logic cm_fail; // Clock monitor fault, synced

    // Sequencer
    rwu_state_t state;
    rwu_state_t next_state;
    logic [CNT_W-1:0] seq_cnt; // Delay counter
    logic [PL_W-1:0] pin_low_cnt; // Consecutive low samples
    logic pin_low_done;
    logic sys_rst; // Whole-system reset
    logic int_event; // Watchdog or monitor event

    // Bus side
    logic acc;
    rwu_wsel_t wsel;
    logic [31:0] rd_val;
    logic rd_ctrl;
    logic [7:0] wbyte;

    // Control register
    logic wdog_enable;
    logic [1:0] tsel; // {timeout_select_hi, timeout_select_lo}
    logic clock_monitor_enable;
    logic ctrl_lock; // Set by the first control write
    logic wdog_reset_flag;

    // Watchdogs
    logic key_armed; // 55 seen, waiting for AA
    logic wd1_restart;
    logic wd1_en;
    logic [W1-1:0] wd1_cnt;
    logic [W1-1:0] wd1_lim;
    logic wd1_to;
    logic wd2_en;
    logic [WD2_BITS-1:0] wd2_cnt;
    logic wd2_clear;
    logic wd2_to;

    // Two flops on mode, option enable, pin and clock fail; only stage b is used
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            sync_a <= 4'h0;
            sync_b <= 4'h0;
        end else begin
            sync_a <= {clock_fail, rst_pin_in, option_wdog_enable, first_compat_mode};
            sync_b <= sync_a;
        end
    end
    assign mode1 = sync_b[0];
    assign opt_en = sync_b[1];
    assign pin_hi = sync_b[2];
    assign cm_fail = sync_b[3] && clock_monitor_enable;

    // Core is held while not running; vector fetched on release
    assign sys_rst = (state != S_RUN);
    assign cpu_reset = sys_rst;

    // Internal cause: either watchdog or the clock monitor
    assign int_event = wd1_to || wd2_to || cm_fail;

    // Pin is taken as a reset once low for the minimum width
    assign pin_low_done = !pin_hi && (pin_low_cnt == PL_W'(PIN_LOW_CYCLES - 1));

    // Sequencer transitions
    always_comb begin
        next_state = state;
        case (state)
            S_POR: begin
                // Stabilisation delay after power-on
                if (seq_cnt == CNT_W'(STAB_CYCLES - 1)) begin
                    next_state = S_WAIT;
                end
            end
            S_INT: begin
                // Short reset for internal causes; pin pulsed in first mode only
                if (seq_cnt == CNT_W'(INT_DRIVE_CYCLES - 1)) begin
                    next_state = S_WAIT;
                end
            end
            S_WAIT: begin
                // External party may keep us in reset
                if (pin_hi) begin
                    next_state = S_RUN;
                end
            end
            S_RUN: begin
                // Internal causes win; in first mode they must drive the pin
                if (int_event) begin
                    next_state = S_INT;
                end else if (pin_low_done) begin
                    next_state = S_WAIT;
                end
            end
            default: begin
                next_state = S_POR;
            end
        endcase
    end

    // State register; power-on always starts the long delay
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            state <= S_POR;
        end else begin
            state <= next_state;
        end
    end

    // Delay counter restarts on every state change
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            seq_cnt <= '0;
        end else if (next_state != state) begin
            seq_cnt <= '0;
        end else if (state == S_POR || state == S_INT) begin
            seq_cnt <= seq_cnt + CNT_W'(1);
        end
    end

    // Width filter on the pin, counted only while running
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            pin_low_cnt <= '0;
        end else if (state != S_RUN || pin_hi) begin
            pin_low_cnt <= '0;
        end else if (pin_low_cnt != PL_W'(PIN_LOW_CYCLES - 1)) begin
            pin_low_cnt <= pin_low_cnt + PL_W'(1);
        end
    end

    // One-cycle pulse: load program counter from the vector
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            reset_vector_load <= 1'b0;
        end else begin
            reset_vector_load <= (state == S_WAIT) && pin_hi;
        end
    end

    // Pin drive: open-drain low, first mode only
    assign rst_pin_out = 1'b0;
    assign rst_pin_oe = mode1 && (state == S_POR || state == S_INT);

    // Zero-wait slave, always OKAY
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign acc = hsel && hready && htrans[HTRANS_ACTIVE_BIT];
    assign rd_ctrl = acc && !hwrite && (haddr == ADDR_CONTROL);
    assign wbyte = hwdata[7:0];

    // Read mux; unmapped and write-only addresses give zero
    always_comb begin
        rd_val = 32'h0000_0000;
        if (haddr == ADDR_CLEAR_OPTION) begin
            rd_val[7:0] = port_interrupt_option;
        end else if (haddr == ADDR_CONTROL) begin
            rd_val[CTRL_FLAG] = wdog_reset_flag;
            rd_val[CTRL_CME] = clock_monitor_enable;
            rd_val[CTRL_WDOG_EN] = wdog_enable;
            rd_val[CTRL_SEL_HI] = tsel[1];
            rd_val[CTRL_SEL_LO] = tsel[0]; // Bits 7..5 stay zero
        end
        // Service key falls to the zero default
    end

    // Address phase: latch write target, capture read data
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            wsel <= W_NONE;
        end else if (acc && hwrite) begin
            if (haddr == ADDR_CLEAR_OPTION) begin
                wsel <= W_CLEAR;
            end else if (haddr == ADDR_SERVICE_KEY) begin
                wsel <= W_KEY;
            end else if (haddr == ADDR_CONTROL) begin
                wsel <= W_CTRL;
            end else begin
                wsel <= W_NONE;
            end
        end else begin
            wsel <= W_NONE;
        end
    end

    // Read data registered so it stands through the data phase
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            hrdata <= 32'h0000_0000;
        end else if (acc && !hwrite) begin
            hrdata <= rd_val;
        end
    end

    // Control bits: one write after each reset, later ones ignored
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            wdog_enable <= 1'b0;
            tsel <= SEL_RESET;
            clock_monitor_enable <= 1'b0;
            ctrl_lock <= 1'b0;
        end else if (sys_rst) begin
            wdog_enable <= 1'b0;
            tsel <= SEL_RESET;
            clock_monitor_enable <= 1'b0;
            ctrl_lock <= 1'b0;
        end else if (wsel == W_CTRL && !ctrl_lock) begin
            wdog_enable <= wbyte[CTRL_WDOG_EN];
            tsel <= {wbyte[CTRL_SEL_HI], wbyte[CTRL_SEL_LO]};
            clock_monitor_enable <= wbyte[CTRL_CME];
            ctrl_lock <= 1'b1;
        end
    end

    // Sticky cause flag; survives the reset it reports, set beats read
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            wdog_reset_flag <= FLAG_RESET;
        end else if (state == S_RUN && int_event) begin
            wdog_reset_flag <= 1'b1;
        end else if (rd_ctrl) begin
            wdog_reset_flag <= 1'b0;
        end
    end

    // Key sequencer: 55 arms, AA fires only when armed
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            key_armed <= 1'b0;
        end else if (sys_rst || wd1_restart) begin
            key_armed <= 1'b0;
        end else if (wsel == W_KEY) begin
            key_armed <= (wbyte == KEY_ARM);
        end
    end
    assign wd1_restart = (wsel == W_KEY) && (wbyte == KEY_FIRE) && key_armed;

    // First watchdog: 2^base prescale, then 1/4/16/64
    assign wd1_en = mode1 && wdog_enable;
    assign wd1_lim = (W1'(1) << (WD1_BASE_LOG2 + 2 * tsel)) - W1'(1);
    assign wd1_to = wd1_en && (wd1_cnt == wd1_lim);

    // No wait-mode input: counting never pauses for it
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            wd1_cnt <= '0;
        end else if (sys_rst || stop_entry || !wd1_en) begin
            wd1_cnt <= '0;
        end else if (wd1_restart) begin
            wd1_cnt <= '0;
        end else begin
            wd1_cnt <= wd1_cnt + W1'(1);
        end
    end

    // Second watchdog: times out when the top stage sets
    assign wd2_en = !mode1 && opt_en;
    assign wd2_clear = (wsel == W_CLEAR) && !wbyte[CLEAR_BIT];
    assign wd2_to = wd2_en && wd2_cnt[WD2_BITS-1];

    // Other clear-register bits have no effect here
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            wd2_cnt <= '0;
        end else if (sys_rst || stop_entry || !wd2_en) begin
            wd2_cnt <= '0;
        end else if (wd2_clear) begin
            wd2_cnt <= '0;
        end else begin
            wd2_cnt <= wd2_cnt + WD2_BITS'(1);
        end
    end

    // Checks
    a_pin_drive: assert property (@(posedge clock) disable iff (!resetn)
        (state == S_INT && mode1) |-> rst_pin_oe && !rst_pin_out)
        else $error("pin not driven on internal reset");
    a_pin_input: assert property (@(posedge clock) disable iff (!resetn)
        !mode1 |-> !rst_pin_oe)
        else $error("pin driven in second mode");
    a_por_len: assert property (@(posedge clock) disable iff (!resetn)
        (state == S_POR && seq_cnt == CNT_W'(STAB_CYCLES - 2)) |=> state == S_POR ##1 state == S_WAIT)
        else $error("power-on delay wrong length");
    a_pin_release: assert property (@(posedge clock) disable iff (!resetn)
        (state == S_WAIT && pin_hi) |=> state == S_RUN && reset_vector_load && !cpu_reset)
        else $error("release sequence wrong");
    a_pin_reset: assert property (@(posedge clock) disable iff (!resetn)
        (state == S_RUN && !int_event && !pin_hi && $past(!pin_hi) && $past(state) == S_RUN)
        |=> cpu_reset)
        else $error("pin low not taken as reset");
    a_key_fire: assert property (@(posedge clock) disable iff (!resetn)
        (wsel == W_KEY && wbyte == KEY_FIRE && key_armed && !sys_rst) |=> wd1_cnt == '0)
        else $error("key sequence did not restart");
    a_key_other: assert property (@(posedge clock) disable iff (!resetn)
        (wd1_en && !sys_rst && !stop_entry && wsel == W_KEY && wbyte != KEY_FIRE && !wd1_to)
        |=> wd1_cnt == $past(wd1_cnt) + W1'(1))
        else $error("other key value changed count");
    a_timeout_rst: assert property (@(posedge clock) disable iff (!resetn)
        (state == S_RUN && (wd1_to || wd2_to)) |=> state == S_INT ##1 cpu_reset [*3])
        else $error("timeout gave no reset");
    a_flag_set: assert property (@(posedge clock) disable iff (!resetn)
        (state == S_RUN && int_event) |=> wdog_reset_flag)
        else $error("cause flag not set");
    a_flag_clear: assert property (@(posedge clock) disable iff (!resetn)
        (rd_ctrl && !(state == S_RUN && int_event)) |=> !wdog_reset_flag)
        else $error("control read left flag set");
    a_ctrl_once: assert property (@(posedge clock) disable iff (!resetn)
        (ctrl_lock && !sys_rst) |=> $stable(wdog_enable) && $stable(tsel)
        && $stable(clock_monitor_enable))
        else $error("locked control bits changed");
    a_ctrl_zero: assert property (@(posedge clock) disable iff (!resetn)
        $past(rd_ctrl) |-> hrdata[7:5] == 3'h0 && hrdata[CTRL_FLAG] == $past(wdog_reset_flag))
        else $error("control read data wrong");
    a_stop_clear: assert property (@(posedge clock) disable iff (!resetn)
        stop_entry |=> wd1_cnt == '0 && wd2_cnt == '0)
        else $error("stop entry left count");
    a_clr_wd2: assert property (@(posedge clock) disable iff (!resetn)
        (wsel == W_CLEAR && !wbyte[CLEAR_BIT]) |=> wd2_cnt == '0)
        else $error("clear write ignored");
endmodule // rwu_top

// >>> design/rwu_pkg.sv
// Constants, register map and types of the reset and watchdog unit.
// Assumes one 50 MHz bus clock and an AHB-Lite slave port with 32-bit data.
package rwu_pkg;
    // Register byte addresses
    localparam logic [31:0] ADDR_CLEAR_OPTION = 32'h0000_3ff0;
    localparam logic [31:0] ADDR_SERVICE_KEY = 32'h0000_3ff4;
    localparam logic [31:0] ADDR_CONTROL = 32'h0000_3ff8;
    // Control register field positions
    localparam int CTRL_SEL_LO = 0;
    localparam int CTRL_SEL_HI = 1;
    localparam int CTRL_WDOG_EN = 2;
    localparam int CTRL_CME = 3;
    localparam int CTRL_FLAG = 4;
    // Clear bit position in the clear/option register
    localparam int CLEAR_BIT = 0;
    // Values after reset
    localparam logic [1:0] SEL_RESET = 2'h0;
    localparam logic FLAG_RESET = 1'b0;
    // Service key values
    localparam logic [7:0] KEY_ARM = 8'h55;
    localparam logic [7:0] KEY_FIRE = 8'haa;
    // Timing
    localparam int CLK_PERIOD_NS = 20;
    localparam int STAB_CYCLES = 4064;
    localparam int PIN_LOW_NS = 30;
    localparam int PIN_LOW_CYCLES = (PIN_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int INT_DRIVE_CYCLES = 4;
    localparam int WD1_BASE_LOG2_DEF = 15;
    localparam int WD2_BITS_DEF = 18;
    localparam int CNT_W = 12;
    localparam int PL_W = 3;
    // AHB transfer type bit that marks an active transfer
    localparam int HTRANS_ACTIVE_BIT = 1;
    // Reset sequencer states
    typedef enum logic [1:0] {S_POR, S_WAIT, S_RUN, S_INT} rwu_state_t;
    // Write target latched in the address phase
    typedef enum logic [1:0] {W_NONE, W_CLEAR, W_KEY, W_CTRL} rwu_wsel_t;
endpackage

// >>> bench/rwu_pin_partner.sv
// Board-side model of the circuitry sharing the active-low reset pin.
// Assumes the bench tells it when the board pulls the pin low.
`timescale 1ns/1ps
module rwu_pin_partner (
    input wire logic dev_oe,
    input wire logic dev_out,
    input wire logic hold_low,
    output logic pin_level
);
    // Open-drain wire with pull-up: either party may pull it low
    // Board keeps it low as long as asked, past the delay too
    assign pin_level = !((dev_oe && !dev_out) || hold_low);
endmodule // rwu_pin_partner

// >>> bench/rwu_top_bench.sv
// Self-checking bench of the reset and watchdog unit over AHB-Lite.
// Assumes short watchdog parameters and the board model on the reset pin.
`timescale 1ns/1ps
module rwu_top_bench;
    import rwu_pkg::*;
    localparam int WD1_LOG2 = 3; // Shortened first watchdog base
    localparam int WD2_W = 5; // Shortened second watchdog width
    localparam int WD1_SPAN = 1 << (WD1_LOG2 + 6); // Select code 11
    localparam int WD2_SPAN = 1 << (WD2_W - 1);
    logic clock = 1'b0;
    logic resetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0000_0000;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0000_0000;
    logic hreadyout, hresp;
    logic [31:0] hrdata;
    logic first_compat_mode = 1'b1;
    logic option_wdog_enable = 1'b0;
    logic clock_fail = 1'b0;
    logic stop_entry = 1'b0;
    logic [7:0] port_interrupt_option = 8'ha5;
    logic hold_low = 1'b0; // Board pulls the pin
    logic pin_level, rst_pin_out, rst_pin_oe, cpu_reset, reset_vector_load;
    int n_errors = 0;
    int n_compared = 0;
    int cyc = 0; // Free cycle count for timing
    int n, t0;
    logic [31:0] rd;
    logic vec_seen;

    // Clock at 50 MHz
    always #(CLK_PERIOD_NS / 2) clock = ~clock;
    always @(posedge clock) cyc <= cyc + 1;

    rwu_top #(.WD1_BASE_LOG2(WD1_LOG2), .WD2_BITS(WD2_W)) u_dut (
        .clock(clock), .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .first_compat_mode(first_compat_mode), .option_wdog_enable(option_wdog_enable),
        .clock_fail(clock_fail), .stop_entry(stop_entry),
        .port_interrupt_option(port_interrupt_option), .rst_pin_in(pin_level),
        .rst_pin_out(rst_pin_out), .rst_pin_oe(rst_pin_oe), .cpu_reset(cpu_reset),
        .reset_vector_load(reset_vector_load)
    );

    rwu_pin_partner u_pin (
        .dev_oe(rst_pin_oe), .dev_out(rst_pin_out), .hold_low(hold_low), .pin_level(pin_level)
    );

    // Counts, verdict and end of run
    task complete_run;
        $display("counts: %0d compared, %0d wrong", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task give_up;
        n_errors++;
        complete_run();
    endtask

    task check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Bounded wait for hready sampled high at a rising edge
    task wait_ready;
        int k;
        k = 0;
        @(posedge clock);
        while (hreadyout !== 1'b1) begin
            if (k == 50) give_up();
            k++;
            @(posedge clock);
        end
    endtask

    // One single word transfer: address phase, then data phase
    task bus(input logic wr, input logic [31:0] a, input logic [7:0] d);
        @(posedge clock);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= wr;
        wait_ready();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {24'h00_0000, d};
        wait_ready();
        rd = hrdata;
    endtask

    task wr(input logic [31:0] a, input logic [7:0] d);
        bus(1'b1, a, d);
    endtask

    task rdchk(input logic [31:0] a, input logic [31:0] exp);
        bus(1'b0, a, 8'h00);
        check(rd, exp);
    endtask

    // Bounded wait for the core reset level; notes any vector load seen
    task wait_level(input logic want, input int bound, output int cnt);
        cnt = 0;
        vec_seen = 1'b0;
        while (cpu_reset !== want) begin
            if (cnt == bound) give_up();
            @(posedge clock);
            cnt++;
            if (reset_vector_load === 1'b1) vec_seen = 1'b1;
        end
        @(posedge clock);
        if (reset_vector_load === 1'b1) vec_seen = 1'b1;
    endtask

    // Hang guard
    initial begin
        repeat (100000) @(posedge clock);
        give_up();
    end

    initial begin
        repeat (3) @(posedge clock);
        resetn <= 1'b1;
        // Power-on delay in first mode, pin driven low throughout
        repeat (100) @(posedge clock);
        check(cpu_reset, 1'b1);
        check(rst_pin_oe, 1'b1);
        repeat (3900) @(posedge clock);
        check(cpu_reset, 1'b1);
        wait_level(1'b0, 200, n);
        check(n >= 64 && n <= 75, 1'b1);
        check(vec_seen, 1'b1);
        check(rst_pin_oe, 1'b0);
        $display("test power_on done");
        // Register map after reset
        rdchk(ADDR_CONTROL, 32'h0000_0000);
        rdchk(ADDR_SERVICE_KEY, 32'h0000_0000);
        rdchk(ADDR_CLEAR_OPTION, {24'h00_0000, port_interrupt_option});
        rdchk(32'h0000_0100, 32'h0000_0000);
        wr(ADDR_CONTROL, 8'he8);
        wr(ADDR_CONTROL, 8'h07); // Second write must be ignored
        rdchk(ADDR_CONTROL, 32'h0000_0001 << CTRL_CME);
        $display("test registers done");
        // Clock monitor reset with monitor enabled
        clock_fail <= 1'b1;
        wait_level(1'b1, 20, n);
        check(rst_pin_oe, 1'b1);
        check(rst_pin_out, 1'b0);
        check({hreadyout, hresp}, 32'h0000_0002);
        clock_fail <= 1'b0;
        wait_level(1'b0, 50, n);
        check(vec_seen, 1'b1);
        rdchk(ADDR_CONTROL, 32'h0000_0001 << CTRL_FLAG);
        rdchk(ADDR_CONTROL, 32'h0000_0000);
        $display("test clock_monitor done");
        // First watchdog: longest select, serviced, then a broken key pair
        wr(ADDR_CONTROL, 8'h07);
        repeat (3) begin
            repeat (300) @(posedge clock);
            wr(ADDR_SERVICE_KEY, KEY_ARM);
            wr(ADDR_SERVICE_KEY, KEY_FIRE);
        end
        check(cpu_reset, 1'b0);
        t0 = cyc;
        wr(ADDR_SERVICE_KEY, KEY_ARM);
        wr(ADDR_SERVICE_KEY, 8'h12);
        wr(ADDR_SERVICE_KEY, KEY_FIRE);
        wait_level(1'b1, 600, n);
        check(cyc - t0 >= WD1_SPAN - 6 && cyc - t0 <= WD1_SPAN + 6, 1'b1);
        check(rst_pin_oe, 1'b1);
        wait_level(1'b0, 50, n);
        rdchk(ADDR_CONTROL, 32'h0000_0001 << CTRL_FLAG);
        $display("test first_watchdog done");
        // Pin reset: a one-cycle glitch is ignored, a longer low resets
        hold_low <= 1'b1;
        @(posedge clock);
        hold_low <= 1'b0;
        repeat (6) @(posedge clock);
        check(cpu_reset, 1'b0);
        hold_low <= 1'b1;
        wait_level(1'b1, 10, n);
        check(n <= 6, 1'b1);
        hold_low <= 1'b0;
        wait_level(1'b0, 8, n);
        check(vec_seen, 1'b1);
        $display("test pin_reset done");
        // First watchdog again with select code 01, span of 2^(base+2)
        wr(ADDR_CONTROL, 8'h05);
        t0 = cyc;
        wait_level(1'b1, 60, n);
        check(cyc - t0 >= 30 && cyc - t0 <= 38, 1'b1);
        wait_level(1'b0, 50, n);
        $display("test timeout_select done");
        // Second mode: pin held low past the delay, then option watchdog
        first_compat_mode <= 1'b0;
        option_wdog_enable <= 1'b1;
        hold_low <= 1'b1;
        resetn <= 1'b0;
        repeat (3) @(posedge clock);
        resetn <= 1'b1;
        repeat (4150) @(posedge clock);
        check(cpu_reset, 1'b1);
        check(rst_pin_oe, 1'b0);
        hold_low <= 1'b0;
        wait_level(1'b0, 8, n);
        check(vec_seen, 1'b1);
        repeat (4) begin
            wr(ADDR_CLEAR_OPTION, 8'hfe);
            repeat (6) @(posedge clock);
        end
        stop_entry <= 1'b1;
        @(posedge clock);
        stop_entry <= 1'b0;
        // Long enough that only the stop clear keeps the count short
        repeat (10) @(posedge clock);
        wr(ADDR_CLEAR_OPTION, 8'hfe);
        check(cpu_reset, 1'b0);
        t0 = cyc;
        wait_level(1'b1, 40, n);
        check(cyc - t0 >= WD2_SPAN - 2 && cyc - t0 <= WD2_SPAN + 6, 1'b1);
        check(rst_pin_oe, 1'b0);
        wait_level(1'b0, 50, n);
        rdchk(ADDR_CONTROL, 32'h0000_0001 << CTRL_FLAG);
        $display("test second_watchdog done");
        complete_run();
    end
endmodule // rwu_top_bench
